// *** hdl/tkd_defs.svh ***
// Timing, threshold and reset constants of the touch key decision logic
`ifndef TKD_DEFS_SVH
`define TKD_DEFS_SVH

// ----------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------
`define TKD_CLK_NS        20

// ----------------------------------------------------------------------
// Times in their own units, and cycle counts derived from them
// ----------------------------------------------------------------------
`define TKD_MS_NS         1000000
`define TKD_MS_CYC        (`TKD_MS_NS / `TKD_CLK_NS)
`define TKD_SETTLE_NS     500000
`define TKD_SETTLE_CYC    ((`TKD_SETTLE_NS + `TKD_CLK_NS - 1) / `TKD_CLK_NS)
`define TKD_PULSE_NS      500
`define TKD_PULSE_CYC     (`TKD_PULSE_NS / `TKD_CLK_NS)

// Millisecond figures, counted in 1 ms ticks
`define TKD_POR_PULSE_MS  16'd20
`define TKD_CAL_MS        16'd50
`define TKD_FAST_MS       16'd16
`define TKD_SLOW_MS       16'd64
`define TKD_DRIFT_TCH_MS  16'd3000
`define TKD_DRIFT_AWY_MS  16'd1000
`define TKD_MAXON_MS      16'd30000

// ----------------------------------------------------------------------
// Detection figures
// ----------------------------------------------------------------------
`define TKD_THR_ON        17'd10
`define TKD_THR_OFF       17'd8
`define TKD_INTEG_LIM     3'd5
`define TKD_CAL_SAMPLES   3'd4
`define TKD_SPREAD_MAX    8'sd15
`define TKD_REF_RST       16'h0000
`define TKD_TRIM_RST      8'sd0

`endif

// *** hdl/tkd_pkg.sv ***
// Types shared by the touch key decision logic
package tkd_pkg;

  // --------------------------------------------------------------------
  // Sequencer states, one-hot
  // --------------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_POR    = 7'b000_0001,
    ST_PULSE  = 7'b000_0010,
    ST_WAIT   = 7'b000_0100,
    ST_SETTLE = 7'b000_1000,
    ST_ACQ    = 7'b001_0000,
    ST_EVAL   = 7'b010_0000,
    ST_SLEEP  = 7'b100_0000
  } tkd_state_t;

  // --------------------------------------------------------------------
  // Raw samples of the four channels from the acquisition front end
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [3:0][15:0] raw;
  } tkd_samples_t;

  // --------------------------------------------------------------------
  // Per-acquisition commands from the sequencer to every channel
  // --------------------------------------------------------------------
  typedef struct packed {
    logic clear;     // Drop integrator and detect state
    logic cal_first; // First calibration sample, restart the sum
    logic cal_acc;   // Add sample to the calibration sum
    logic cal_done;  // Load reference from the sum
    logic eval;      // Normal evaluation of the latest sample
    logic drift_up;  // Step reference toward touch
    logic drift_dn;  // Step reference away from touch
  } tkd_chan_ctl_t;

endpackage

// *** hdl/tkd_tick.sv ***
// One-cycle enable pulse divider for the touch key decision logic
`timescale 1ns/1ps
`include "tkd_defs.svh"
module tkd_tick
  import tkd_pkg::*;
#(
  parameter int DIV = `TKD_MS_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Enable pulse, one cycle every DIV cycles
  output logic      tick
);

  logic [15:0] cnt_r;

  // ------------------------------------------------------------------
  // Free-running divider
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= 16'h0000;
      tick  <= 1'b0;
    end else if (cnt_r == 16'(DIV - 1)) begin
      cnt_r <= 16'h0000;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
      tick  <= 1'b0;
    end
  end

endmodule

// *** hdl/tkd_chan.sv ***
// One key channel: reference, threshold, hysteresis and integrator
`timescale 1ns/1ps
`include "tkd_defs.svh"
module tkd_chan
  import tkd_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Commands and sample
  input  wire tkd_chan_ctl_t ctl,
  input  wire logic [15:0]   raw,
  // Confirmed detect state
  output logic               detect
);

  logic [15:0] ref_r;
  logic [17:0] acc_r;
  logic [2:0]  integ_r;

  // Signal above reference by at least thr counts
  function automatic logic exceeds(input logic [15:0] s,
                                   input logic [15:0] r,
                                   input logic [16:0] thr);
    exceeds = {1'b0, s} >= ({1'b0, r} + thr);
  endfunction

  // Average of four samples; the fourth arrives in the cycle of the load,
  // so it is added here rather than read back from the sum register
  function automatic logic [15:0] avg4(input logic [17:0] sum,
                                       input logic [15:0] s);
    logic [17:0] tot;
    tot  = sum + {2'b00, s};
    avg4 = tot[17:2];
  endfunction

  // ------------------------------------------------------------------
  // Reference: calibration average and slow drift
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_r <= `TKD_REF_RST;
    end else if (ctl.cal_done) begin
      ref_r <= avg4(acc_r, raw);
    end else if (ctl.eval && ctl.drift_up && raw > ref_r) begin
      ref_r <= ref_r + 16'h0001;
    end else if (ctl.eval && ctl.drift_dn && raw < ref_r) begin
      ref_r <= ref_r - 16'h0001;
    end
  end

  // Sum of fresh samples; four samples so the average is a shift
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_r <= 18'h0_0000;
    end else if (ctl.cal_acc) begin
      acc_r <= (ctl.cal_first ? 18'h0_0000 : acc_r) + {2'b00, raw};
    end
  end

  // ------------------------------------------------------------------
  // Integrator and detect with hysteresis
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n || ctl.clear) begin
      integ_r <= 3'd0;
      detect  <= 1'b0;
    end else if (ctl.eval) begin
      if (detect) begin
        if (!exceeds(raw, ref_r, `TKD_THR_OFF)) begin
          detect  <= 1'b0;
          integ_r <= 3'd0;
        end
      end else if (exceeds(raw, ref_r, `TKD_THR_ON)) begin
        if (integ_r == `TKD_INTEG_LIM - 3'd1) begin
          detect  <= 1'b1;
          integ_r <= `TKD_INTEG_LIM;
        end else begin
          integ_r <= integ_r + 3'd1;
        end
      end else begin
        integ_r <= 3'd0;
      end
    end
  end

endmodule

// *** hdl/tkd_top.sv ***
// Touch key decision logic: sequencer, lockout, drift and key outputs
`timescale 1ns/1ps
`include "tkd_defs.svh"

module tkd_top
  import tkd_pkg::*;
#(
  parameter int MS_CYC     = `TKD_MS_CYC,
  parameter int SETTLE_CYC = `TKD_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Option straps
  input  wire logic         lockout_option_sense_pin,
  input  wire logic         speed_option_sense_pin,
  // Acquisition front end
  output logic              acq_req,
  input  wire logic         acq_done,
  input  wire tkd_samples_t acq_raw,
  output logic signed [7:0] osc_trim,
  // Status
  output logic              cal_busy,
  // Open-drain key outputs
  output logic [3:0]        key_touch_n_o,
  output logic [3:0]        key_touch_n_oe
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  tkd_state_t    state_r;
  tkd_samples_t  raw_r;
  tkd_chan_ctl_t ctl_r;
  logic          ms_tick;
  logic [15:0]   ms_cnt_r;
  logic [4:0]    pulse_cnt_r;
  logic [14:0]   settle_cnt_r;
  logic [2:0]    cal_idx_r;
  logic          cal_mode_r;
  logic          lockout_r;
  logic          fast_r;
  logic [3:0]    det;
  logic [3:0]    rep_r;
  logic [3:0]    rep_nxt;
  logic          any_det;
  logic [15:0]   drift_tch_r;
  logic [15:0]   drift_awy_r;
  logic          pend_up_r;
  logic          pend_dn_r;
  logic          tch_hit;
  logic          awy_hit;
  logic [15:0]   on_cnt_r;
  logic          recal_r;
  logic          maxon_hit;
  logic          trim_up_r;
  logic [15:0]   sleep_ms;

  assign any_det   = |det;
  assign sleep_ms  = fast_r ? `TKD_FAST_MS : `TKD_SLOW_MS;
  assign tch_hit   = ms_tick && (drift_tch_r == `TKD_DRIFT_TCH_MS - 16'd1);
  assign awy_hit   = ms_tick && (drift_awy_r == `TKD_DRIFT_AWY_MS - 16'd1);
  assign maxon_hit = ms_tick && (on_cnt_r == `TKD_MAXON_MS - 16'd1);

  // --------------------------------------------------------------------
  // Millisecond enable and channels
  // --------------------------------------------------------------------
  tkd_tick #(
    .DIV   (MS_CYC)
  ) u_tick (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (ms_tick)
  );

  for (genvar k = 0; k < 4; k++) begin : g_chan
    tkd_chan u_chan (
      .clk    (clk),
      .rst_n  (rst_n),
      .ctl    (ctl_r),
      .raw    (raw_r.raw[k]),
      .detect (det[k])
    );
  end

  // --------------------------------------------------------------------
  // Straps
  // --------------------------------------------------------------------
  // Caught only during the power-up wait; later changes are ignored
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lockout_r <= 1'b0;
      fast_r    <= 1'b0;
    end else if (state_r == ST_POR) begin
      lockout_r <= lockout_option_sense_pin;
      fast_r    <= speed_option_sense_pin;
    end
  end

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  // Power-up wait, start pulse, calibration, then sleep/settle/burst
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r      <= ST_POR;
      ms_cnt_r     <= 16'h0000;
      pulse_cnt_r  <= 5'd0;
      settle_cnt_r <= 15'd0;
      cal_idx_r    <= 3'd0;
      cal_mode_r   <= 1'b0;
      acq_req      <= 1'b0;
      raw_r        <= '0;
    end else begin
      if (ms_tick) begin
        ms_cnt_r <= ms_cnt_r + 16'h0001;
      end
      case (state_r)
        ST_POR: begin
          if (ms_cnt_r == `TKD_POR_PULSE_MS) begin
            state_r     <= ST_PULSE;
            pulse_cnt_r <= 5'd0;
          end
        end
        ST_PULSE: begin
          pulse_cnt_r <= pulse_cnt_r + 5'd1;
          if (pulse_cnt_r == 5'(`TKD_PULSE_CYC - 1)) begin
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (ms_cnt_r == `TKD_CAL_MS) begin
            state_r      <= ST_SETTLE;
            cal_mode_r   <= 1'b1;
            cal_idx_r    <= 3'd0;
            settle_cnt_r <= 15'd0;
          end
        end
        ST_SLEEP: begin
          if (recal_r) begin
            state_r      <= ST_SETTLE;
            cal_mode_r   <= 1'b1;
            cal_idx_r    <= 3'd0;
            settle_cnt_r <= 15'd0;
          // First tick after entry ends a partial ms, so one more is counted
          end else if (ms_cnt_r == sleep_ms + 16'd1) begin
            state_r      <= ST_SETTLE;
            settle_cnt_r <= 15'd0;
          end
        end
        ST_SETTLE: begin
          settle_cnt_r <= settle_cnt_r + 15'd1;
          if (settle_cnt_r == 15'(SETTLE_CYC - 1)) begin
            state_r <= ST_ACQ;
            acq_req <= 1'b1;
          end
        end
        ST_ACQ: begin
          if (acq_done) begin
            acq_req <= 1'b0;
            raw_r   <= acq_raw;
            state_r <= ST_EVAL;
          end
        end
        ST_EVAL: begin
          // Calibration samples follow each other without sleeping
          if (cal_mode_r && cal_idx_r != `TKD_CAL_SAMPLES - 3'd1) begin
            cal_idx_r    <= cal_idx_r + 3'd1;
            state_r      <= ST_SETTLE;
            settle_cnt_r <= 15'd0;
          end else begin
            cal_mode_r <= 1'b0;
            state_r    <= ST_SLEEP;
            ms_cnt_r   <= 16'h0000;
          end
        end
        default: begin
          state_r <= ST_POR;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Channel commands
  // --------------------------------------------------------------------
  // Registered so every channel sees the latched sample at the same edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl_r <= '0;
    end else begin
      ctl_r.clear     <= maxon_hit;
      ctl_r.cal_acc   <= (state_r == ST_EVAL) && cal_mode_r;
      ctl_r.cal_first <= (state_r == ST_EVAL) && cal_idx_r == 3'd0;
      ctl_r.cal_done  <= (state_r == ST_EVAL) && cal_mode_r &&
                         cal_idx_r == `TKD_CAL_SAMPLES - 3'd1;
      ctl_r.eval      <= (state_r == ST_EVAL) && !cal_mode_r;
      ctl_r.drift_up  <= pend_up_r && !any_det;
      ctl_r.drift_dn  <= pend_dn_r && !any_det;
    end
  end

  // --------------------------------------------------------------------
  // Drift timers
  // --------------------------------------------------------------------
  // Timers hold while any key is in detect, so no step is owed later
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      drift_tch_r <= 16'h0000;
      drift_awy_r <= 16'h0000;
    end else if (!any_det && !cal_mode_r && ms_tick) begin
      drift_tch_r <= tch_hit ? 16'h0000 : drift_tch_r + 16'h0001;
      drift_awy_r <= awy_hit ? 16'h0000 : drift_awy_r + 16'h0001;
    end
  end

  // Pending steps; a new expiry wins over the consume at evaluation
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_up_r <= 1'b0;
      pend_dn_r <= 1'b0;
    end else begin
      if (!any_det && !cal_mode_r && tch_hit) begin
        pend_up_r <= 1'b1;
      end else if (ctl_r.eval || any_det) begin
        pend_up_r <= 1'b0;
      end
      if (!any_det && !cal_mode_r && awy_hit) begin
        pend_dn_r <= 1'b1;
      end else if (ctl_r.eval || any_det) begin
        pend_dn_r <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Stuck-detect timeout
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n || !any_det) begin
      on_cnt_r <= 16'h0000;
    end else if (ms_tick) begin
      on_cnt_r <= maxon_hit ? 16'h0000 : on_cnt_r + 16'h0001;
    end
  end

  // Recalibration request waits for the sequencer to reach sleep
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      recal_r <= 1'b0;
    end else if (maxon_hit) begin
      recal_r <= 1'b1;
    end else if (state_r == ST_SLEEP) begin
      recal_r <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Neighbour-key lockout
  // --------------------------------------------------------------------
  // The key already reported keeps priority; otherwise lowest index
  always_comb begin
    if (!lockout_r) begin
      rep_nxt = det;
    end else if ((rep_r & det) != 4'h0) begin
      rep_nxt = rep_r & det;
    end else begin
      rep_nxt = det & (~det + 4'h1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || ctl_r.clear) begin
      rep_r <= 4'h0;
    end else begin
      rep_r <= rep_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Key pins
  // --------------------------------------------------------------------
  // Open drain: only ever drives low, enable marks the pulled-down key
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      key_touch_n_o  <= 4'h0;
      key_touch_n_oe <= 4'h0;
    end else begin
      key_touch_n_o  <= 4'h0;
      key_touch_n_oe <= rep_nxt & ~{4{ctl_r.clear}};
      if (state_r == ST_PULSE) begin
        key_touch_n_oe[2] <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Spread-spectrum trim and status
  // --------------------------------------------------------------------
  // Triangle sweep in half-percent steps; idle at nominal between bursts
  always_ff @(posedge clk) begin
    if (!rst_n || !acq_req) begin
      osc_trim  <= `TKD_TRIM_RST;
      trim_up_r <= 1'b1;
    end else if (trim_up_r) begin
      osc_trim  <= osc_trim + 8'sd1;
      trim_up_r <= (osc_trim != `TKD_SPREAD_MAX - 8'sd1);
    end else begin
      osc_trim  <= osc_trim - 8'sd1;
      trim_up_r <= (osc_trim == -`TKD_SPREAD_MAX + 8'sd1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cal_busy <= 1'b0;
    end else begin
      cal_busy <= cal_mode_r;
    end
  end

endmodule

// *** tb/tkd_top_monitor.sv ***
// Concurrent checks on the ports of the touch key decision logic
`timescale 1ns/1ps
module tkd_top_monitor #(
  parameter int MS_CYC     = 50000,
  parameter int SETTLE_CYC = 25000
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst_n,
  // Straps and front end
  input wire logic              lockout_option_sense_pin,
  input wire logic              acq_req,
  input wire logic signed [7:0] osc_trim,
  // Status and key outputs
  input wire logic              cal_busy,
  input wire logic [3:0]        key_touch_n_o,
  input wire logic [3:0]        key_touch_n_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ------------------------------------------------------------
  // Helper counters
  // ------------------------------------------------------------
  logic        seen_req_r;
  logic [31:0] cyc_r;
  logic [31:0] quiet_r;

  // Start pulse is told apart from touches: it comes before any burst
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seen_req_r <= 1'b0;
    end else if (acq_req) begin
      seen_req_r <= 1'b1;
    end
  end

  // Cycles since reset release
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cyc_r <= 32'h0000_0000;
    end else begin
      cyc_r <= cyc_r + 32'h0000_0001;
    end
  end

  // Cycles with no burst request, to bound the wake-up settle wait
  always_ff @(posedge clk) begin
    if (!rst_n || acq_req) begin
      quiet_r <= 32'h0000_0000;
    end else begin
      quiet_r <= quiet_r + 32'h0000_0001;
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  sequence s_pulse_high;
    key_touch_n_oe[2] [*8] ##1 key_touch_n_oe[2] [*8] ##1
    key_touch_n_oe[2] [*8] ##1 key_touch_n_oe[2];
  endsequence

  chk_od_data_low: assert property (
    key_touch_n_o == 4'h0) else $error("open-drain data not low");
  chk_trim_idle: assert property (
    !acq_req && !$past(acq_req) |-> osc_trim == 8'sh00)
    else $error("trim not zero outside burst");
  chk_trim_range: assert property (
    osc_trim <= 8'sh0F && osc_trim >= -8'sh0F)
    else $error("trim out of range");
  chk_trim_step: assert property (
    acq_req && $past(acq_req) |->
      osc_trim == $past(osc_trim) + 8'sh01 ||
      osc_trim == $past(osc_trim) - 8'sh01)
    else $error("trim did not sweep by one");
  chk_settle_gap: assert property (
    $rose(acq_req) |-> quiet_r >= SETTLE_CYC)
    else $error("burst started before settle wait");
  chk_pulse_width: assert property (
    $rose(key_touch_n_oe[2]) && !seen_req_r |->
      s_pulse_high ##1 !key_touch_n_oe[2])
    else $error("start pulse width wrong");
  chk_pulse_time: assert property (
    $rose(key_touch_n_oe[2]) && !seen_req_r |->
      cyc_r >= 20 * MS_CYC && cyc_r <= 21 * MS_CYC + 2)
    else $error("start pulse at wrong time");
  chk_cal_quiet: assert property (
    cal_busy && $past(cal_busy) |-> key_touch_n_oe == 4'h0)
    else $error("key output active during calibration");
  chk_lockout_one: assert property (
    lockout_option_sense_pin |-> $onehot0(key_touch_n_oe))
    else $error("more than one key reported under lockout");
endmodule

bind tkd_top tkd_top_monitor #(
  .MS_CYC     (MS_CYC),
  .SETTLE_CYC (SETTLE_CYC)
) tkd_top_monitor_inst (
  .clk                      (clk),
  .rst_n                    (rst_n),
  .lockout_option_sense_pin (lockout_option_sense_pin),
  .acq_req                  (acq_req),
  .osc_trim                 (osc_trim),
  .cal_busy                 (cal_busy),
  .key_touch_n_o            (key_touch_n_o),
  .key_touch_n_oe           (key_touch_n_oe)
);

// *** tb/tkd_host_model.sv ***
// Host side of the key outputs: pull-ups on the open-drain lines
`timescale 1ns/1ps
module tkd_host_model (
  // Open-drain drivers of the device
  input  wire logic [3:0] key_touch_n_o,
  input  wire logic [3:0] key_touch_n_oe,
  // Levels the host reads
  output logic      [3:0] key_pin
);
  // A released line floats up through its resistor, never holds a value
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      key_pin[k] = key_touch_n_oe[k] ? key_touch_n_o[k] : 1'b1;
    end
  end
endmodule

// *** tb/tkd_top_tb.sv ***
// Self-checking bench for the touch key decision logic
`timescale 1ns/1ps
module tkd_top_tb;
  import tkd_pkg::*;
  localparam int MS = 50;
  localparam int ST = 10;

  typedef struct {
    logic [3:0][7:0] d;
    int              n;
    logic [3:0]      t;
  } tkd_row_t;

  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              lockout = 1'b0;
  logic              speed = 1'b1;
  logic              acq_done = 1'b0;
  logic [3:0][7:0]   delta = '0;
  tkd_samples_t      acq_raw;
  logic              acq_req;
  logic signed [7:0] osc_trim;
  logic signed [7:0] tmax = 8'sh00;
  logic signed [7:0] tmin = 8'sh00;
  logic              cal_busy;
  logic [3:0]        ko;
  logic [3:0]        koe;
  logic [3:0]        key_pin;
  logic              slow = 1'b0;
  int                wait_cnt = 0;
  int                gap = 0;
  int                errors = 0;
  int                cmp_count = 0;
  tkd_row_t          rows [9];

  always #10 clk = ~clk;

  tkd_top #(.MS_CYC(MS), .SETTLE_CYC(ST)) tkd_top_inst (
    .clk                      (clk),
    .rst_n                    (rst_n),
    .lockout_option_sense_pin (lockout),
    .speed_option_sense_pin   (speed),
    .acq_req                  (acq_req),
    .acq_done                 (acq_done),
    .acq_raw                  (acq_raw),
    .osc_trim                 (osc_trim),
    .cal_busy                 (cal_busy),
    .key_touch_n_o            (ko),
    .key_touch_n_oe           (koe)
  );

  tkd_host_model tkd_host_model_inst (
    .key_touch_n_o  (ko),
    .key_touch_n_oe (koe),
    .key_pin        (key_pin)
  );

  // ------------------------------------------------------------
  // Front end: answers quickly and slowly in turn, so the sweep
  // reaches both ends of its range
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (acq_req && !acq_done && wait_cnt >= (slow ? 70 : 3)) begin
      acq_done <= 1'b1;
      slow <= ~slow;
      wait_cnt <= 0;
    end else begin
      acq_done <= 1'b0;
      wait_cnt <= acq_req ? wait_cnt + 1 : 0;
    end
    if (osc_trim > tmax) tmax <= osc_trim;
    if (osc_trim < tmin) tmin <= osc_trim;
  end

  // Every channel sits at a base of 100 counts plus its delta
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      acq_raw.raw[k] = 16'h0064 + {8'h00, delta[k]};
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Runs n bursts; stops when the following burst is requested
  task automatic acqs(input int n);
    int i;
    repeat (n) begin
      i = 0;
      while (acq_done !== 1'b1 && i < 9000) begin
        @(negedge clk);
        i++;
      end
      @(negedge clk);
      gap = 0;
      while (acq_req !== 1'b1 && gap < 9000) begin
        @(negedge clk);
        gap++;
      end
      // A front end or sequencer that stalls counts as a mismatch
      if (i >= 9000 || gap >= 9000) errors++;
    end
  endtask

  task automatic step(input logic [3:0][7:0] d, input int n,
                      input logic [3:0] t);
    @(posedge clk);
    delta <= d;
    acqs(n);
    check({28'h0, key_pin}, {28'h0, ~t});
  endtask

  // Straps are set with reset and never moved while running
  task automatic do_reset(input logic lk, input logic sp);
    int i;
    @(posedge clk);
    rst_n <= 1'b0;
    delta <= '0;
    lockout <= lk;
    speed <= sp;
    repeat (12) @(posedge clk);
    check({18'h0, acq_req, cal_busy, osc_trim, key_pin}, 32'h0000_000F);
    rst_n <= 1'b1;
    i = 0;
    while (key_pin[2] !== 1'b0 && i < 2000) begin
      @(negedge clk);
      i++;
    end
    check(32'(i >= 20 * MS - 2 && i <= 21 * MS + 2), 32'h0000_0001);
    i = 0;
    while (key_pin[2] === 1'b0 && i < 100) begin
      @(negedge clk);
      i++;
    end
    check(32'(i), 32'h0000_0019);
    i = 0;
    while (cal_busy !== 1'b1 && i < 3000) begin
      @(negedge clk);
      i++;
    end
    while (cal_busy !== 1'b0 && i < 6000) begin
      @(negedge clk);
      i++;
    end
    check(32'(i < 6000), 32'h0000_0001);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rows = '{'{32'h0000_090A, 5, 4'h1}, '{32'h0C0C_0C0C, 5, 4'hF},
             '{32'h0008_0708, 1, 4'h5}, '{32'h0000_0000, 1, 4'h0},
             '{32'h0A0A_0A0A, 4, 4'h0}, '{32'h0909_0909, 1, 4'h0},
             '{32'h0A0A_0A0A, 4, 4'h0}, '{32'h0A0A_0A0A, 1, 4'hF},
             '{32'h0000_0000, 1, 4'h0}};
    do_reset(1'b0, 1'b1);
    foreach (rows[i]) begin
      step(rows[i].d, rows[i].n, rows[i].t);
    end
    check(32'(gap >= 16 * MS + ST && gap <= 17 * MS + ST + 8), 32'h1);
    // Second reset mid-run: lockout on, slow mode
    do_reset(1'b1, 1'b0);
    step(32'h0000_0C0C, 5, 4'h1);
    step(32'h000C_0C00, 1, 4'h2);
    step(32'h000C_0C0C, 5, 4'h2);
    check(32'(gap >= 64 * MS + ST && gap <= 65 * MS + ST + 8), 32'h1);
    check({24'h0, tmax}, 32'h0000_000F);
    check({24'h0, tmin}, 32'h0000_00F1);
    results();
  end

  // Both runs together need about 65k cycles
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    results();
  end
endmodule
